/* File: inc/rop_pkg.sv */
// Package for the raster-operation combiner: register map, field layout,
// reset value, function codes, pixel-path types.
// Assumes a 32-bit AXI4-Lite register bus and a 32-bit pixel word.
package rop_pkg;

   // Register byte offsets
   localparam logic [11:0] ROP_CTRL_OFFSET   = 12'h000;  // raster_operation_control
   localparam logic [11:0] ROP_STATUS_OFFSET = 12'h004;  // Combiner status

   // Field positions in the control register
   localparam int DEST_BYTE_LANE_LSB   = 10;
   localparam int DEST_BITMAP_KIND_LSB = 8;
   localparam int ROP_CODE_LSB         = 0;

   // Writable bits of the control register; the rest read as zero
   localparam logic [31:0] ROP_CTRL_MASK  = 32'h0000_0f0f;
   localparam logic [31:0] ROP_CTRL_RESET = 32'h0000_0003;

   // AXI responses
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // Boolean function codes
   typedef enum logic [3:0] {
      ROP_CLEAR = 4'h0, ROP_AND     = 4'h1, ROP_AND_REV = 4'h2, ROP_COPY  = 4'h3,
      ROP_AND_I = 4'h4, ROP_NOOP    = 4'h5, ROP_XOR     = 4'h6, ROP_OR    = 4'h7,
      ROP_NOR   = 4'h8, ROP_EQUIV   = 4'h9, ROP_INVERT  = 4'ha, ROP_OR_REV = 4'hb,
      ROP_COPY_I = 4'hc, ROP_OR_I   = 4'hd, ROP_NAND    = 4'he, ROP_SET   = 4'hf
   } rop_code_t;

   // Destination bitmap kinds
   typedef enum logic [1:0] {
      BM_PACKED8   = 2'h0,
      BM_UNPACKED8 = 2'h1,
      BM_12BPP     = 2'h2,
      BM_24BPP     = 2'h3
   } bitmap_kind_t;

   // Decoded control register
   typedef struct packed {
      logic [1:0]   dest_byte_lane;
      bitmap_kind_t dest_bitmap_kind;
      rop_code_t    rop_code;
   } rop_ctrl_t;

   // Pixel request from the pipeline
   typedef struct packed {
      logic [31:0] src;       // Source pixel word
      logic [31:0] dst;       // Destination word (memory or DMA)
      logic        force_copy; // Block fill, block stipple or DMA-write copy
      logic        dma_write;  // DMA-write copy: dst from bus side
   } pix_req_t;

   // Pixel result toward memory
   typedef struct packed {
      logic [31:0] data;       // Merged word
      logic [3:0]  byte_en;    // Bytes to write
      logic        rmw;        // Destination read was needed
   } pix_res_t;

endpackage : rop_pkg

/* File: logic/raster_op_combiner.sv */
// Raster-operation stage: control register over AXI4-Lite, Boolean merge
// of source and destination pixels, write-buffer drain on control write.
// Assumes the pipeline holds a request until ready and reports write
// buffer emptiness; memory read of the destination is done outside.
`timescale 1ns/1ps
module raster_op_combiner (
   // Clock and reset
   input  wire logic              ref_clk_i,
   input  wire logic              reset_n_i,
   // AXI4-Lite write address
   input  wire logic              s_axi_awvalid_i,
   output      logic              s_axi_awready_o,
   input  wire logic [11:0]       s_axi_awaddr_i,
   // AXI4-Lite write data
   input  wire logic              s_axi_wvalid_i,
   output      logic              s_axi_wready_o,
   input  wire logic [31:0]       s_axi_wdata_i,
   input  wire logic [3:0]        s_axi_wstrb_i,
   // AXI4-Lite write response
   output      logic              s_axi_bvalid_o,
   input  wire logic              s_axi_bready_i,
   output      logic [1:0]        s_axi_bresp_o,
   // AXI4-Lite read address
   input  wire logic              s_axi_arvalid_i,
   output      logic              s_axi_arready_o,
   input  wire logic [11:0]       s_axi_araddr_i,
   // AXI4-Lite read data
   output      logic              s_axi_rvalid_o,
   input  wire logic              s_axi_rready_i,
   output      logic [31:0]       s_axi_rdata_o,
   output      logic [1:0]        s_axi_rresp_o,
   // Write buffer state
   input  wire logic              wbuf_empty_i,
   output      logic              wbuf_drain_o,
   // Pixel request
   input  wire logic              pix_valid_i,
   output      logic              pix_ready_o,
   input  wire rop_pkg::pix_req_t pix_req_i,
   // Pixel result
   output      logic              res_valid_o,
   output      rop_pkg::pix_res_t res_o
);

   ////////////////////////////////////////////////////////////////////////
   // Functions

   // Bitwise merge; each result bit sees only its own src and dst bits
   function automatic logic [31:0] rop_apply(input rop_pkg::rop_code_t c,
                                             input logic [31:0] s,
                                             input logic [31:0] d);
      logic [31:0] r;
      r = '0;
      for (int i = 0; i < 32; i++) begin
         // Truth table index {s,d}: code bit 3-{s,d}
         r[i] = c[{1'b1, 1'b1} - {s[i], d[i]}];
      end
      return r;
   endfunction : rop_apply

   // Whether the function reads the destination
   function automatic logic needs_dst(input rop_pkg::rop_code_t c);
      return (c[3:2] != c[1:0]) || (c[3] != c[2]) || (c[1] != c[0]) ?
             !(c == rop_pkg::ROP_COPY || c == rop_pkg::ROP_COPY_I) : 1'b0;
   endfunction : needs_dst

   ////////////////////////////////////////////////////////////////////////
   // Write channel capture

   logic        aw_full_q;   // Write address held
   logic        w_full_q;    // Write data held
   logic [11:0] aw_addr_q;   // Held write address
   logic [31:0] w_data_q;    // Held write data
   logic [3:0]  w_strb_q;    // Held strobes
   logic        b_valid_q;   // Response pending
   logic [1:0]  b_resp_q;    // Response code
   logic        wr_go;       // Both halves present and drain complete
   logic        ctrl_hit;    // Write targets control register

   assign s_axi_awready_o = !aw_full_q && !b_valid_q;
   assign s_axi_wready_o  = !w_full_q && !b_valid_q;
   assign ctrl_hit        = (aw_addr_q == rop_pkg::ROP_CTRL_OFFSET);
   // Control writes stall until the write buffer is empty
   assign wr_go           = aw_full_q && w_full_q && (!ctrl_hit || wbuf_empty_i);
   assign wbuf_drain_o    = aw_full_q && w_full_q && ctrl_hit;

   // Address and data halves, either order
   always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         aw_full_q <= 1'b0;
         w_full_q  <= 1'b0;
         aw_addr_q <= 12'h000;
         w_data_q  <= 32'h0000_0000;
         w_strb_q  <= 4'h0;
      end else begin
         if (s_axi_awvalid_i && s_axi_awready_o) begin
            aw_full_q <= 1'b1;
            aw_addr_q <= s_axi_awaddr_i;
         end else if (wr_go) begin
            aw_full_q <= 1'b0;
         end
         if (s_axi_wvalid_i && s_axi_wready_o) begin
            w_full_q <= 1'b1;
            w_data_q <= s_axi_wdata_i;
            w_strb_q <= s_axi_wstrb_i;
         end else if (wr_go) begin
            w_full_q <= 1'b0;
         end
      end
   end

   // Write response
   always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         b_valid_q <= 1'b0;
         b_resp_q  <= rop_pkg::RESP_OKAY;
      end else if (wr_go) begin
         b_valid_q <= 1'b1;
         b_resp_q  <= (ctrl_hit || aw_addr_q == rop_pkg::ROP_STATUS_OFFSET) ?
                      rop_pkg::RESP_OKAY : rop_pkg::RESP_SLVERR;
      end else if (s_axi_bready_i) begin
         b_valid_q <= 1'b0;
      end
   end

   assign s_axi_bvalid_o = b_valid_q;
   assign s_axi_bresp_o  = b_resp_q;

   ////////////////////////////////////////////////////////////////////////
   // Control register

   logic [31:0]       ctrl_q;  // Stored control word
   rop_pkg::rop_ctrl_t ctrl;   // Decoded fields

   // Byte-strobed update of writable bits only
   always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         ctrl_q <= rop_pkg::ROP_CTRL_RESET;
      end else if (wr_go && ctrl_hit) begin
         for (int b = 0; b < 4; b++) begin
            if (w_strb_q[b]) begin
               ctrl_q[b*8 +: 8] <= w_data_q[b*8 +: 8] & rop_pkg::ROP_CTRL_MASK[b*8 +: 8];
            end
         end
      end
   end

   // Field extraction
   assign ctrl.dest_byte_lane   = ctrl_q[rop_pkg::DEST_BYTE_LANE_LSB +: 2];
   assign ctrl.dest_bitmap_kind =
      rop_pkg::bitmap_kind_t'(ctrl_q[rop_pkg::DEST_BITMAP_KIND_LSB +: 2]);
   assign ctrl.rop_code         = rop_pkg::rop_code_t'(ctrl_q[rop_pkg::ROP_CODE_LSB +: 4]);

   ////////////////////////////////////////////////////////////////////////
   // Read channel

   logic        r_valid_q;  // Read data pending
   logic [31:0] r_data_q;   // Read data
   logic [1:0]  r_resp_q;   // Read response
   logic        res_busy_q; // Result awaiting consumption (status)

   assign s_axi_arready_o = !r_valid_q;

   // Register read mux
   always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         r_valid_q <= 1'b0;
         r_data_q  <= 32'h0000_0000;
         r_resp_q  <= rop_pkg::RESP_OKAY;
      end else if (s_axi_arvalid_i && s_axi_arready_o) begin
         r_valid_q <= 1'b1;
         r_resp_q  <= rop_pkg::RESP_OKAY;
         unique case (s_axi_araddr_i)
            rop_pkg::ROP_CTRL_OFFSET:   r_data_q <= ctrl_q;
            rop_pkg::ROP_STATUS_OFFSET: r_data_q <= {29'h000_0000, wbuf_drain_o,
                                                     res_busy_q, !wbuf_empty_i};
            default: begin
               r_data_q <= 32'h0000_0000;
               r_resp_q <= rop_pkg::RESP_SLVERR;
            end
         endcase
      end else if (s_axi_rready_i) begin
         r_valid_q <= 1'b0;
      end
   end

   assign s_axi_rvalid_o = r_valid_q;
   assign s_axi_rdata_o  = r_data_q;
   assign s_axi_rresp_o  = r_resp_q;

   ////////////////////////////////////////////////////////////////////////
   // Pixel combine

   rop_pkg::rop_code_t eff_code;  // Code after mode override
   logic [3:0]         lane_en;   // Destination byte enables

   // Block and DMA-write copy modes ignore the stored code
   assign eff_code = pix_req_i.force_copy ? rop_pkg::ROP_COPY : ctrl.rop_code;

   // Destination bytes per bitmap kind in a 32-bpp buffer
   always_comb begin
      unique case (ctrl.dest_bitmap_kind)
         rop_pkg::BM_PACKED8:   lane_en = 4'hf;
         rop_pkg::BM_UNPACKED8: lane_en = 4'h1 << ctrl.dest_byte_lane;
         rop_pkg::BM_12BPP:     lane_en = 4'h7;
         rop_pkg::BM_24BPP:     lane_en = 4'h7;
      endcase
   end

   // Updating the result stalls new pixels; control writes take effect between
   assign pix_ready_o = !res_busy_q && !wbuf_drain_o;

   // Result register
   always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         res_busy_q <= 1'b0;
         res_o      <= '0;
      end else if (pix_valid_i && pix_ready_o) begin
         res_busy_q   <= 1'b1;
         // Dst is memory data except in DMA-write copy
         res_o.data    <= rop_apply(eff_code, pix_req_i.src, pix_req_i.dst);
         res_o.byte_en <= lane_en;
         res_o.rmw     <= needs_dst(eff_code) && !pix_req_i.dma_write;
      end else begin
         res_busy_q <= 1'b0;
      end
   end

   assign res_valid_o = res_busy_q;

   ////////////////////////////////////////////////////////////////////////
   // Assertions

   property p_ctrl_reset;
      @(posedge ref_clk_i) $rose(reset_n_i) |-> ctrl_q == 32'h0000_0003;
   endproperty
   a_ctrl_reset: assert property (p_ctrl_reset) else $error("control not reset");

   property p_drain_hold;
      @(posedge ref_clk_i) disable iff (!reset_n_i)
         (wbuf_drain_o && !wbuf_empty_i) |=> $stable(ctrl_q);
   endproperty
   a_drain_hold: assert property (p_drain_hold) else $error("control changed early");

   property p_force_copy;
      @(posedge ref_clk_i) disable iff (!reset_n_i)
         (pix_valid_i && pix_ready_o && pix_req_i.force_copy) |=>
         res_o.data == $past(pix_req_i.src);
   endproperty
   a_force_copy: assert property (p_force_copy) else $error("forced copy wrong");

   property p_xor;
      @(posedge ref_clk_i) disable iff (!reset_n_i)
         (pix_valid_i && pix_ready_o && !pix_req_i.force_copy && ctrl_q[3:0] == 4'h6) |=>
         res_o.data == ($past(pix_req_i.src) ^ $past(pix_req_i.dst));
   endproperty
   a_xor: assert property (p_xor) else $error("xor merge wrong");

   property p_nand;
      @(posedge ref_clk_i) disable iff (!reset_n_i)
         (pix_valid_i && pix_ready_o && !pix_req_i.force_copy && ctrl_q[3:0] == 4'he) |=>
         res_o.data == ~($past(pix_req_i.src) & $past(pix_req_i.dst));
   endproperty
   a_nand: assert property (p_nand) else $error("nand merge wrong");

   property p_lane;
      @(posedge ref_clk_i) disable iff (!reset_n_i)
         (pix_valid_i && pix_ready_o && ctrl_q[9:8] == 2'h1) |=>
         res_o.byte_en == (4'h1 << $past(ctrl_q[11:10]));
   endproperty
   a_lane: assert property (p_lane) else $error("byte lane wrong");

   property p_rmw_copy;
      @(posedge ref_clk_i) disable iff (!reset_n_i)
         (pix_valid_i && pix_ready_o && pix_req_i.force_copy) |=> !res_o.rmw;
   endproperty
   a_rmw_copy: assert property (p_rmw_copy) else $error("copy flagged rmw");

   property p_rmw_and;
      @(posedge ref_clk_i) disable iff (!reset_n_i)
         (pix_valid_i && pix_ready_o && !pix_req_i.force_copy && !pix_req_i.dma_write
          && ctrl_q[3:0] == 4'h1) |=> res_o.rmw;
   endproperty
   a_rmw_and: assert property (p_rmw_and) else $error("and lacks rmw");

   property p_res_pulse;
      @(posedge ref_clk_i) disable iff (!reset_n_i) res_valid_o |=> !res_valid_o;
   endproperty
   a_res_pulse: assert property (p_res_pulse) else $error("result held too long");

endmodule : raster_op_combiner

/* File: dv/tb.sv */
// Self-checking bench for the raster-operation combiner: register access
// over AXI4-Lite, every function code, forced copy, byte enables, drain.
// Assumes the design package is compiled first; no partner model is used.
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin checks_done++; if ((got) !== (exp)) begin bad_count++; \
   $display("unexpected %s exp %h got %h", nm, exp, got); end end
module tb;
   ////////////////////////////////////////////////////////////////////////
   // Bench signals
   logic              ref_clk    = 1'b0;  // Core clock
   logic              reset_n    = 1'b0;  // Active-low reset
   logic              awvalid    = 1'b0;  // Write address
   logic              awready;
   logic [11:0]       awaddr     = 12'h000;
   logic              wvalid     = 1'b0;  // Write data
   logic              wready;
   logic [31:0]       wdata      = 32'h0000_0000;
   logic [3:0]        wstrb      = 4'hf;
   logic              bvalid;             // Write response
   logic              bready     = 1'b1;  // Always ready for a response
   logic [1:0]        bresp;
   logic              arvalid    = 1'b0;  // Read address
   logic              arready;
   logic [11:0]       araddr     = 12'h000;
   logic              rvalid;             // Read data
   logic              rready     = 1'b1;  // Always ready for read data
   logic [31:0]       rdata;
   logic [1:0]        rresp;
   logic              wbuf_empty = 1'b1;  // Write buffer state
   logic              wbuf_drain;
   logic              pix_valid  = 1'b0;  // Pixel request
   logic              pix_ready;
   rop_pkg::pix_req_t pix_req    = '0;
   logic              res_valid;          // Pixel result
   rop_pkg::pix_res_t res;
   int                bad_count  = 0;     // Mismatches
   int                checks_done = 0;    // Comparisons
   logic [1:0]        rsp;                // Last response code
   logic [31:0]       rd;                 // Last read word
   logic [3:0]        be_exp;             // Expected byte enables

   // Half period of 2.5 ns gives 200 MHz
   always #2.5 ref_clk = ~ref_clk;

   raster_op_combiner i_raster_op_combiner (
      .ref_clk_i(ref_clk), .reset_n_i(reset_n),
      .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready), .s_axi_awaddr_i(awaddr),
      .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready), .s_axi_wdata_i(wdata),
      .s_axi_wstrb_i(wstrb), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
      .s_axi_bresp_o(bresp), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready),
      .s_axi_araddr_i(araddr), .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready),
      .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .wbuf_empty_i(wbuf_empty),
      .wbuf_drain_o(wbuf_drain), .pix_valid_i(pix_valid), .pix_ready_o(pix_ready),
      .pix_req_i(pix_req), .res_valid_o(res_valid), .res_o(res));

   ////////////////////////////////////////////////////////////////////////
   // Expected merge of one word, bit by bit
   function automatic logic [31:0] rop_f(input logic [3:0] c, input logic [31:0] s,
                                         input logic [31:0] d);
      case (c)
         4'h0: rop_f = 32'h0000_0000;
         4'h1: rop_f = s & d;
         4'h2: rop_f = s & ~d;
         4'h3: rop_f = s;
         4'h4: rop_f = ~s & d;
         4'h5: rop_f = d;
         4'h6: rop_f = s ^ d;
         4'h7: rop_f = s | d;
         4'h8: rop_f = ~s & ~d;
         4'h9: rop_f = ~s ^ d;
         4'ha: rop_f = ~d;
         4'hb: rop_f = s | ~d;
         4'hc: rop_f = ~s;
         4'hd: rop_f = ~s | d;
         4'he: rop_f = ~s | ~d;
         default: rop_f = 32'hffff_ffff;
      endcase
   endfunction : rop_f

   ////////////////////////////////////////////////////////////////////////
   // Write: both halves offered together, each dropped when taken
   task automatic axi_write(input logic [11:0] a, input logic [31:0] d);
      logic aw_t;
      logic w_t;
      logic b_t;
      b_t = 1'b0;
      awaddr  <= a;
      wdata   <= d;
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      while (!b_t) begin
         @(negedge ref_clk);
         aw_t = awvalid && awready;
         w_t  = wvalid && wready;
         b_t  = bvalid && bready;
         if (b_t) rsp = bresp;
         @(posedge ref_clk);
         if (aw_t) awvalid <= 1'b0;
         if (w_t) wvalid <= 1'b0;
      end
   endtask : axi_write

   // Read: data taken at the falling edge before the rising edge that completes the handshake
   task automatic axi_read(input logic [11:0] a);
      logic ar_t;
      logic r_t;
      r_t = 1'b0;
      araddr  <= a;
      arvalid <= 1'b1;
      while (!r_t) begin
         @(negedge ref_clk);
         ar_t = arvalid && arready;
         r_t  = rvalid && rready;
         if (r_t) begin
            rd  = rdata;
            rsp = rresp;
         end
         @(posedge ref_clk);
         if (ar_t) arvalid <= 1'b0;
      end
   endtask : axi_read

   // Pixel: hold until accepted, result pulse checked one cycle later
   task automatic pix_send(input logic [31:0] s, input logic [31:0] d,
                           input logic fc, input logic dma);
      logic t;
      t = 1'b0;
      pix_req   <= '{src: s, dst: d, force_copy: fc, dma_write: dma};
      pix_valid <= 1'b1;
      while (!t) begin
         @(negedge ref_clk);
         t = pix_valid && pix_ready;
         @(posedge ref_clk);
         if (t) pix_valid <= 1'b0;
      end
      @(negedge ref_clk);
      `CHK("res_valid", 1'b1, res_valid)
      @(posedge ref_clk);
   endtask : pix_send

   // Verdict and end of run
   task automatic test_done();
      if (bad_count == 0 && checks_done > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : test_done

   ////////////////////////////////////////////////////////////////////////
   // Watchdog far beyond the few hundred cycles the tests need
   initial begin
      repeat (20000) @(posedge ref_clk);
      bad_count++;
      test_done();
   end

   // Main sequence
   initial begin
      repeat (12) @(posedge ref_clk);
      reset_n <= 1'b1;
      @(posedge ref_clk);
      axi_read(rop_pkg::ROP_CTRL_OFFSET);
      `CHK("ctrl reset", rop_pkg::ROP_CTRL_RESET, rd)
      // Reserved bits read as zero
      axi_write(rop_pkg::ROP_CTRL_OFFSET, 32'hffff_ffff);
      axi_read(rop_pkg::ROP_CTRL_OFFSET);
      `CHK("ctrl mask", 32'h0000_0f0f, rd)
      // Unmapped place answers with an error
      axi_write(12'h008, 32'h0000_0005);
      `CHK("bresp unmapped", rop_pkg::RESP_SLVERR, rsp)
      axi_read(12'h008);
      `CHK("rresp unmapped", rop_pkg::RESP_SLVERR, rsp)
      `CHK("rdata unmapped", 32'h0000_0000, rd)
      // Status takes writes without effect; control keeps its value
      axi_write(rop_pkg::ROP_STATUS_OFFSET, 32'h0000_0005);
      `CHK("bresp status", rop_pkg::RESP_OKAY, rsp)
      axi_read(rop_pkg::ROP_CTRL_OFFSET);
      `CHK("ctrl kept", 32'h0000_0f0f, rd)
      // Byte strobes: only the low byte is written
      wstrb <= 4'h1;
      axi_write(rop_pkg::ROP_CTRL_OFFSET, 32'h0000_0005);
      axi_read(rop_pkg::ROP_CTRL_OFFSET);
      `CHK("ctrl strobe", 32'h0000_0f05, rd)
      wstrb <= 4'hf;
      // Every function code on all four bit pairs
      for (int c = 0; c < 16; c++) begin
         axi_write(rop_pkg::ROP_CTRL_OFFSET, {28'h0000_000, c[3:0]});
         `CHK("bresp", rop_pkg::RESP_OKAY, rsp)
         pix_send(32'h3333_3333, 32'h5555_5555, 1'b0, 1'b0);
         `CHK("merge", rop_f(c[3:0], 32'h3333_3333, 32'h5555_5555), res.data)
         `CHK("rmw", !(c inside {0, 3, 12, 15}), res.rmw)
      end
      // Block and DMA-write modes copy the source whatever the code
      axi_write(rop_pkg::ROP_CTRL_OFFSET, 32'h0000_0006);
      pix_send(32'h1234_5678, 32'hffff_0000, 1'b1, 1'b0);
      `CHK("force data", 32'h1234_5678, res.data)
      `CHK("force rmw", 1'b0, res.rmw)
      pix_send(32'h0f0f_a5a5, 32'h9999_9999, 1'b1, 1'b1);
      `CHK("dma data", 32'h0f0f_a5a5, res.data)
      `CHK("dma rmw", 1'b0, res.rmw)
      // Byte enables per bitmap kind and lane; lane zero for 12/24-bpp
      for (int k = 0; k < 4; k++) begin
         for (int l = 0; l < 4; l++) begin
            if (k < 2 || l == 0) begin
               axi_write(rop_pkg::ROP_CTRL_OFFSET, {20'h0_0000, l[1:0], k[1:0], 8'h03});
               axi_read(rop_pkg::ROP_CTRL_OFFSET);
               `CHK("ctrl fields", {20'h0_0000, l[1:0], k[1:0], 8'h03}, rd)
               pix_send(32'hcafe_f00d, 32'h0000_0000, 1'b0, 1'b0);
               be_exp = (k == 0) ? 4'hf : (k == 1) ? (4'h1 << l) : 4'h7;
               `CHK("byte_en", be_exp, res.byte_en)
            end
         end
      end
      // Control write held off until the write buffer is empty
      wbuf_empty <= 1'b0;
      fork
         axi_write(rop_pkg::ROP_CTRL_OFFSET, 32'h0000_000a);
         begin
            repeat (6) @(negedge ref_clk);
            `CHK("drain", 1'b1, wbuf_drain)
            `CHK("bvalid early", 1'b0, bvalid)
            `CHK("pix_ready drain", 1'b0, pix_ready)
            @(posedge ref_clk);
            // Status: drain pending, buffer not empty, no result
            axi_read(rop_pkg::ROP_STATUS_OFFSET);
            `CHK("status drain", 32'h0000_0005, rd)
            `CHK("rresp status", rop_pkg::RESP_OKAY, rsp)
            // Old control value still in force while draining
            axi_read(rop_pkg::ROP_CTRL_OFFSET);
            `CHK("ctrl during drain", 32'h0000_0303, rd)
            wbuf_empty <= 1'b1;
         end
      join
      `CHK("bresp drain", rop_pkg::RESP_OKAY, rsp)
      pix_send(32'h3333_3333, 32'h5555_5555, 1'b0, 1'b0);
      `CHK("merge after drain", 32'haaaa_aaaa, res.data)
      test_done();
   end
endmodule : tb
